// *** core/eblane_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module eblane_core (
    // Clock and reset
    input  wire logic                                i_clk,
    input  wire logic                                i_reset,
    // Core-side request
    input  wire logic                                i_req,
    input  wire logic                                i_req_write,
    input  wire logic [eblane_pkg::LOW_W-1:0]        i_req_addr,
    input  wire logic [eblane_pkg::LANES-1:0]        i_req_be,
    input  wire logic [eblane_pkg::DATA_W-1:0]       i_req_wdata,
    input  wire logic                                i_req_done,
    // Bus outputs
    output logic                                     o_addr_qualifier_valid,
    output logic                                     o_xfer_is_write,
    output logic [eblane_pkg::ADDR_HI:eblane_pkg::ADDR_LO] o_bus_word_addr,
    output logic [eblane_pkg::LANES-1:0]             o_byte_lane_enable,
    output logic [eblane_pkg::DATA_W-1:0]            o_bus_write_word,
    // Bus read return
    input  wire logic [eblane_pkg::DATA_W-1:0]       i_bus_read_word,
    input  wire logic                                i_read_word_valid,
    // Core-side read result
    output logic [eblane_pkg::DATA_W-1:0]            o_read_data,
    output logic                                     o_read_strobe
);
    import eblane_pkg::*;

    // Transaction hold states
    typedef enum logic [0:0] {
        EBLANE_IDLE = 1'b0,
        EBLANE_HOLD = 1'b1
    } eblane_state_t;

    // Registered bus fields and read result
    eblane_state_t        state_q, state_d;
    logic                 wr_q, wr_d;
    logic [LOW_W-1:0]     addr_q, addr_d;
    logic [LANES-1:0]     be_q, be_d;
    logic [DATA_W-1:0]    wd_q, wd_d;
    logic [DATA_W-1:0]    rd_q, rd_d;
    logic                 rs_q, rs_d;

    // Decoded qualifiers and lane masks
    logic                 holding;
    logic                 rd_take;
    logic [DATA_W-1:0]    req_mask;
    logic [DATA_W-1:0]    take_mask;

    // Qualifier high while a transaction is held
    assign holding = (state_q == EBLANE_HOLD);
    // Read data taken only for a held read with valid data
    assign rd_take = holding && !wr_q && i_read_word_valid;

    // Checker sequences: start, hold, finish and read sample
    sequence s_start;
        !holding && i_req;
    endsequence

    sequence s_hold_on;
        holding && !i_req_done;
    endsequence

    sequence s_finish;
        holding && i_req_done;
    endsequence

    sequence s_read_hit;
        holding && !wr_q && i_read_word_valid;
    endsequence

    // Per-lane masks and lane checks
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        // Request lanes gate write data at capture
        assign req_mask[g*LANE_W +: LANE_W]  = {LANE_W{i_req_be[g]}};
        // Enabled lanes take read data
        assign take_mask[g*LANE_W +: LANE_W] = {LANE_W{rd_take && be_q[g]}};

        a_lane_read: assert property (@(posedge i_clk) disable iff (i_reset)
            s_read_hit ##0 be_q[g] |=>
            o_read_data[g*LANE_W +: LANE_W] == $past(i_bus_read_word[g*LANE_W +: LANE_W]))
            else $error("enabled read lane not sampled");
        a_lane_keep: assert property (@(posedge i_clk) disable iff (i_reset)
            s_read_hit ##0 !be_q[g] |=> $stable(o_read_data[g*LANE_W +: LANE_W]))
            else $error("disabled read lane changed");
        a_lane_wclear: assert property (@(posedge i_clk) disable iff (i_reset)
            s_start ##0 !i_req_be[g] |=>
            o_bus_write_word[g*LANE_W +: LANE_W] == {LANE_W{1'b0}})
            else $error("write lane driven without enable");
        a_lane_wdata: assert property (@(posedge i_clk) disable iff (i_reset)
            s_start ##0 i_req_be[g] |=>
            o_bus_write_word[g*LANE_W +: LANE_W] == $past(i_req_wdata[g*LANE_W +: LANE_W]))
            else $error("enabled write lane not driven");
    end

    // Request capture and hold until done
    always_comb begin
        state_d = state_q;
        wr_d    = wr_q;
        addr_d  = addr_q;
        be_d    = be_q;
        wd_d    = wd_q;
        case (state_q)
            EBLANE_IDLE: begin
                if (i_req) begin
                    state_d = EBLANE_HOLD;
                    wr_d    = i_req_write;
                    addr_d  = i_req_addr;
                    be_d    = i_req_be;
                    wd_d    = i_req_wdata & req_mask;
                end
            end
            EBLANE_HOLD: begin
                if (i_req_done) begin
                    state_d = EBLANE_IDLE;
                    be_d    = BE_RESET;
                    wd_d    = DATA_RESET;
                end
            end
            default: begin
                state_d = EBLANE_IDLE;
                be_d    = BE_RESET;
                wd_d    = DATA_RESET;
            end
        endcase
    end

    // Read lane merge; lanes not enabled keep their old byte
    always_comb begin
        rd_d = (rd_q & ~take_mask) | (i_bus_read_word & take_mask);
        rs_d = rd_take;
    end

    // State registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= EBLANE_IDLE;
            wr_q    <= 1'b0;
            addr_q  <= ADDR_RESET;
            be_q    <= BE_RESET;
            wd_q    <= DATA_RESET;
            rd_q    <= DATA_RESET;
            rs_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            wr_q    <= wr_d;
            addr_q  <= addr_d;
            be_q    <= be_d;
            wd_q    <= wd_d;
            rd_q    <= rd_d;
            rs_q    <= rs_d;
        end
    end

    // Bus drive straight from registers
    always_comb begin
        o_addr_qualifier_valid = holding;
        o_xfer_is_write        = wr_q;
        o_bus_word_addr        = {ADDR_TOP_CONST, addr_q};
        o_byte_lane_enable     = be_q;
        o_bus_write_word       = wd_q;
        o_read_data            = rd_q;
        o_read_strobe          = rs_q;
    end

    // Address and lane checks
    a_top_addr_const: assert property (@(posedge i_clk) disable iff (i_reset)
        o_bus_word_addr[ADDR_HI -: TOP_W] == ADDR_TOP_CONST)
        else $error("upper address bits not constant");
    a_be_idle_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_addr_qualifier_valid |-> o_byte_lane_enable == BE_RESET)
        else $error("byte enables active without qualifier");
    a_lane0_read: assert property (@(posedge i_clk) disable iff (i_reset)
        s_read_hit ##0 be_q[0] |=> o_read_data[7:0] == $past(i_bus_read_word[7:0]))
        else $error("lane 0 read not sampled");
    a_lane3_keep: assert property (@(posedge i_clk) disable iff (i_reset)
        s_read_hit ##0 !be_q[3] |=> $stable(o_read_data[31:24]))
        else $error("disabled lane 3 changed");

    // Read strobe checks
    a_read_strobe: assert property (@(posedge i_clk) disable iff (i_reset)
        o_read_strobe |-> $past(rd_take))
        else $error("read strobe without valid read");
    a_strobe_follow: assert property (@(posedge i_clk) disable iff (i_reset)
        s_read_hit |=> o_read_strobe)
        else $error("valid read not strobed");
    a_read_refused: assert property (@(posedge i_clk) disable iff (i_reset)
        !(holding && !wr_q) |=> !o_read_strobe)
        else $error("read strobe outside a held read");

    // Hold checks while a transaction stands, and the lane 1 write data mask
    a_write_held: assert property (@(posedge i_clk) disable iff (i_reset)
        s_hold_on |=> o_xfer_is_write == $past(o_xfer_is_write))
        else $error("write indicator changed mid transaction");
    a_addr_held: assert property (@(posedge i_clk) disable iff (i_reset)
        s_hold_on |=> $stable(o_bus_word_addr))
        else $error("address changed mid transaction");
    a_be_held: assert property (@(posedge i_clk) disable iff (i_reset)
        s_hold_on |=> $stable(o_byte_lane_enable))
        else $error("byte enables changed mid transaction");
    a_wdata_held: assert property (@(posedge i_clk) disable iff (i_reset)
        s_hold_on |=> $stable(o_bus_write_word))
        else $error("write data changed mid transaction");
    a_wdata_mask: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_byte_lane_enable[1] |-> o_bus_write_word[15:8] == 8'h00)
        else $error("disabled write lane driven");

    // Capture and release checks
    a_capture: assert property (@(posedge i_clk) disable iff (i_reset)
        s_start |=> o_addr_qualifier_valid && o_byte_lane_enable == $past(i_req_be))
        else $error("request not captured");
    a_capture_fields: assert property (@(posedge i_clk) disable iff (i_reset)
        s_start |=> o_xfer_is_write == $past(i_req_write) &&
        o_bus_word_addr[ADDR_HI-TOP_W:ADDR_LO] == $past(i_req_addr))
        else $error("request fields not captured");
    a_finish_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        s_finish |=> !o_addr_qualifier_valid && o_byte_lane_enable == BE_RESET)
        else $error("transaction not released");
endmodule : eblane_core
`default_nettype wire

// *** core/eblane_pkg.sv ***
package eblane_pkg;
    // Data path geometry
    localparam int DATA_W   = 32;
    localparam int LANES    = 4;
    localparam int LANE_W   = 8;
    localparam int ADDR_HI  = 35;
    localparam int ADDR_LO  = 2;
    localparam int ADDR_W   = ADDR_HI - ADDR_LO + 1;
    localparam int TOP_W    = 4;
    localparam int LOW_W    = ADDR_W - TOP_W;
    // Constant upper address bits
    localparam logic [TOP_W-1:0] ADDR_TOP_CONST = 4'h0;
    // Reset values
    localparam logic [LANES-1:0]  BE_RESET   = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [LOW_W-1:0]  ADDR_RESET = 30'h0000_0000;
endpackage : eblane_pkg

// *** dv/eblane_target.sv ***
`timescale 1ns/1ps
`default_nettype none
module eblane_target (
    // Bus side
    input  wire logic        i_clk,
    input  wire logic        i_valid,
    input  wire logic        i_write,
    input  wire logic [29:0] i_addr,
    input  wire logic        i_slow,
    // Answers
    output logic             o_done,
    output logic             o_rvalid,
    output logic [31:0]      o_rdata
);
    int   n;
    logic d;
    initial {n, o_done, o_rvalid, o_rdata} = '0;
    // Answer at once or after three waits; released data toggles
    always @(negedge i_clk) begin
        n = (i_valid && !o_done) ? n + 1 : 0;
        d = n > (i_slow ? 3 : 0);
        o_done <= d;
        o_rvalid <= d && !i_write;
        o_rdata <= (d && !i_write) ? {i_addr, 2'h3} : ~o_rdata;
    end
endmodule : eblane_target
`default_nettype wire

// *** dv/eblane_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module eblane_core_tb;
    import eblane_pkg::*;
    logic        clk = 0, rst = 1, req = 0, wr = 0, done, rv, av, xw, rs;
    logic        pav = 0, pxw = 0, pend = 0;
    logic [29:0] ad = '0;
    logic [3:0]  be = '0, ob, pob = '0;
    logic [31:0] wd = '0, rd, od, ow, m, rdm = '0;
    logic [35:2] oa;
    logic [70:0] q[$];
    int          error_cnt = 0, checked = 0, seed = 11;
    // Compare one value
    task automatic chk(input string s, input logic [70:0] e, v);
        checked++;
        if (e !== v) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", s, e, v);
        end
    endtask : chk
    task automatic test_done;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    initial forever #5 clk = ~clk;
    // Hang guard
    initial begin
        #100000;
        error_cnt++;
        test_done();
    end
    eblane_core i_dut (.i_clk(clk), .i_reset(rst), .i_req(req), .i_req_write(wr),
        .i_req_addr(ad), .i_req_be(be), .i_req_wdata(wd), .i_req_done(done),
        .o_addr_qualifier_valid(av), .o_xfer_is_write(xw), .o_bus_word_addr(oa),
        .o_byte_lane_enable(ob), .o_bus_write_word(ow), .i_bus_read_word(rd),
        .i_read_word_valid(rv), .o_read_data(od), .o_read_strobe(rs));
    eblane_target i_tgt (.i_clk(clk), .i_valid(av), .i_write(xw), .i_addr(oa[31:2]),
        .i_slow(oa[2]), .o_done(done), .o_rvalid(rv), .o_rdata(rd));
    // Back-to-back random requests with noted bus fields
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 0;
        for (int k = 0; k < 60; k++) begin
            while (av) @(negedge clk);
            {wr, ad, be, wd} = 67'({$random(seed), $random(seed), $random(seed)});
            m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            req = 1;
            q.push_back({wr, ADDR_TOP_CONST, ad, be, wd & m});
            @(negedge clk) req = 0;
        end
        repeat (8) @(negedge clk);
        chk("queue_left", 71'h0, 71'(q.size()));
        test_done();
    end
    // Watch bus fields, idle lanes and merged read data
    always @(negedge clk) if (!rst) begin
        pend = rv && pav && !pxw;
        for (int i = 0; i < 4; i++) if (pend && pob[i]) rdm[8*i+:8] = rd[8*i+:8];
        if (av && !pav) chk("bus_fields", q.pop_front(), {xw, oa, ob, ow});
        if (!av) chk("idle_lanes", 71'h0, 71'(ob));
        if (pend || rs) chk("read_data", 71'({pend, rdm}), 71'({rs, od}));
        {pav, pxw, pob} = {av, xw, ob};
    end
endmodule : eblane_core_tb
`default_nettype wire
